// File: logic/flash_host_defines.svh
// Purpose: timing counts, command addresses and codes for the flash host
// Assumes: 50 MHz clock, flash pins sampled synchronously
// Notes: a least time rounds up to whole cycles, a longest time rounds down
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define T_AS_NS 10
`define T_WP_NS 200
`define T_WPH_NS 200
`define T_ACC_NS 200
`define T_OEHP_NS 150
`define AS_CYC `CYC_MIN(`T_AS_NS)
`define WP_CYC `CYC_MIN(`T_WP_NS)
`define WPH_CYC `CYC_MIN(`T_WPH_NS)
// one extra cycle because the data pins are sampled on a clock edge
`define ACC_CYC (`CYC_MIN(`T_ACC_NS) + 1)
`define OEHP_CYC `CYC_MIN(`T_OEHP_NS)

`define T_BP_MAX_US 50
`define BP_MAX_CYC (`T_BP_MAX_US * 1000 / `CLK_PERIOD_NS)
`define T_EC_MAX_S 10
`define EC_MAX_CYC (`T_EC_MAX_S * 64'd1000000000 / `CLK_PERIOD_NS)

`define CMD_ADDR_A 15'h5555
`define CMD_ADDR_B 15'h2aaa
`define CODE_UNLOCK_A 8'haa
`define CODE_UNLOCK_B 8'h55
`define CODE_ERASE_SETUP 8'h80
`define CODE_PROGRAM 8'ha0
`define CODE_ID_ENTRY 8'h90
`define CODE_ID_EXIT 8'hf0
`define CODE_CHIP_ERASE 8'h10
`define CODE_SECTOR_ERASE 8'h30
`define CODE_LOCKOUT 8'h40
`define TOGGLE_BIT 6

`endif

// File: logic/flash_host_pkg.sv
// Purpose: types shared by the flash host modules
// Assumes: nothing
// Notes: none
package flash_host_pkg;

    typedef enum logic [2:0] {
        CMD_READ,
        CMD_PROGRAM,
        CMD_CHIP_ERASE,
        CMD_SECTOR_ERASE,
        CMD_LOCKOUT,
        CMD_ID_ENTRY,
        CMD_ID_EXIT3,
        CMD_ID_EXIT1
    } cmd_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SETUP,
        PH_STROBE,
        PH_RECOVER
    } bus_phase_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_READ,
        ST_POLL
    } host_state_t;

endpackage

// File: logic/flash_bus_cycle.sv
// Purpose: one timed read or write cycle on the flash pins
// Assumes: inputs synchronous to i_clock
// Notes: writes strobe write_strobe_n and chip_select_n together
`timescale 1ns/1ns
`include "flash_host_defines.svh"

module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic i_clock, // system clock
    input wire logic i_rst_n, // synchronous reset
    input wire logic i_clk_en, // freezes all state when low
    input wire logic i_start, // begin a cycle, taken when idle
    input wire logic i_write, // 1 write, 0 read
    input wire logic [17:0] i_addr, // cycle address
    input wire logic [15:0] i_wdata, // write data
    input wire logic [15:0] i_dq, // flash data pins in
    output logic o_idle, // ready for i_start
    output logic o_done, // last cycle of a bus cycle
    output logic [15:0] o_rdata, // captured read data
    output logic o_ce_n, // chip select
    output logic o_oe_n, // output enable
    output logic o_we_n, // write strobe
    output logic [17:0] o_addr, // flash address
    output logic [15:0] o_dq, // flash data out
    output logic o_dq_oe_n // low while driving data
);

    bus_phase_t ph_r;
    bus_phase_t ph_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [15:0] rdata_r;
    logic ce_n_r;
    logic oe_n_r;
    logic we_n_r;
    logic [17:0] addr_r;
    logic [15:0] dq_r;
    logic dq_oe_n_r;
    logic [7:0] phase_len;
    logic phase_end;
    logic take;

    assign take = i_start && (ph_r == PH_IDLE);
    assign wr_nxt = take ? i_write : wr_r;
    assign phase_len = (ph_r == PH_SETUP) ? 8'(`AS_CYC) :
                       (ph_r == PH_STROBE) ? (wr_r ? 8'(`WP_CYC) : 8'(`ACC_CYC)) :
                       (wr_r ? 8'(`WPH_CYC) : 8'(`OEHP_CYC));
    assign phase_end = (ph_r != PH_IDLE) && (cnt_r == phase_len - 8'h01);
    assign cnt_nxt = (phase_end || ph_r == PH_IDLE) ? 8'h00 : cnt_r + 8'h01;

    always_comb
    begin
        ph_nxt = ph_r;
        case (ph_r)
            PH_IDLE: if (take) ph_nxt = PH_SETUP;
            PH_SETUP: if (phase_end) ph_nxt = PH_STROBE;
            PH_STROBE: if (phase_end) ph_nxt = PH_RECOVER;
            PH_RECOVER: if (phase_end) ph_nxt = PH_IDLE;
            default: ph_nxt = PH_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ph_r <= PH_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            rdata_r <= 16'h0000;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            addr_r <= 18'h00000;
            dq_r <= 16'h0000;
            dq_oe_n_r <= 1'b1;
        end
        else if (i_clk_en)
        begin
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            if (take)
            begin
                addr_r <= i_addr;
                dq_r <= i_wdata;
            end
            if (ph_r == PH_STROBE && phase_end && !wr_r)
                rdata_r <= i_dq;
            ce_n_r <= (ph_nxt != PH_STROBE);
            oe_n_r <= !(ph_nxt == PH_STROBE && !wr_nxt);
            we_n_r <= !(ph_nxt == PH_STROBE && wr_nxt);
            dq_oe_n_r <= !(wr_nxt && ph_nxt != PH_IDLE);
        end
    end

    assign o_idle = (ph_r == PH_IDLE);
    assign o_done = (ph_r == PH_RECOVER) && phase_end;
    assign o_rdata = rdata_r;
    assign o_ce_n = ce_n_r;
    assign o_oe_n = oe_n_r;
    assign o_we_n = we_n_r;
    assign o_addr = addr_r;
    assign o_dq = dq_r;
    assign o_dq_oe_n = dq_oe_n_r;

endmodule

// File: logic/flash_host.sv
// Purpose: host controller issuing command sequences to a parallel NOR flash
// Assumes: 50 MHz clock, one command at a time from the user port
// Notes: completion of program and erase is found by toggle-bit polling
// How it works
// - chip erase ends with a write at command address 5555.
// - final erase write carries 10 for chip, 30 for sector.
// - sector erase final write goes to an address inside the sector.
// - command writes keep output_enable_n high, strobe with chip select low.
// - each poll read pulses output enable and chip select together.
// - all polling reads use one fixed address.
// - both id exit forms are accepted and end id mode.
// - only data bits 7..0 carry codes; addresses use bits 14..0.
`timescale 1ns/1ns
`include "flash_host_defines.svh"

module flash_host
    import flash_host_pkg::*;
#(
    parameter logic [31:0] PROG_TIMEOUT_CYC = 32'(`BP_MAX_CYC),
    parameter logic [31:0] ERASE_TIMEOUT_CYC = 32'(`EC_MAX_CYC)
)
(
    input wire logic I_CLOCK, // 50 MHz clock
    input wire logic I_RST_N, // synchronous reset, active low
    input wire logic I_CLK_EN, // freezes all state when low
    input wire logic I_CMD_VALID, // command request
    input wire cmd_t I_CMD, // command kind
    input wire logic [17:0] I_ADDR, // target address
    input wire logic [15:0] I_DATA, // program data
    output logic O_CMD_READY, // command accepted when high with valid
    output logic O_DONE, // one-cycle pulse at command end
    output logic O_TIMEOUT, // last command timed out
    output logic [15:0] O_RDATA, // last read or final poll data
    output logic O_ID_MODE, // flash believed in identification mode
    output logic O_CE_N, // flash chip select
    output logic O_OE_N, // flash output enable
    output logic O_WE_N, // flash write strobe
    output logic [17:0] O_ADDR, // flash address
    input wire logic [15:0] I_DQ, // flash data in
    output logic [15:0] O_DQ, // flash data out
    output logic O_DQ_OE_N // low while driving flash data
);

    host_state_t state_r;
    host_state_t state_nxt;
    cmd_t cmd_r;
    logic [17:0] addr_r;
    logic [15:0] data_r;
    logic [2:0] step_r;
    logic issued_r;
    logic prev_valid_r;
    logic prev_tog_r;
    logic [31:0] poll_cnt_r;
    logic timeout_r;
    logic [15:0] rdata_r;
    logic id_mode_r;
    logic done_r;

    logic bus_idle;
    logic bus_done;
    logic [15:0] bus_rdata;
    logic bus_start;
    logic bus_write;
    logic [17:0] seq_addr;
    logic [15:0] seq_data;
    logic [2:0] last_step;
    logic needs_poll;
    logic [31:0] poll_limit;
    logic poll_expired;
    logic poll_equal;
    logic take;
    logic write_last;
    logic finish;

    // address of a sequence write; codes use only address bits 14..0
    function automatic logic [17:0] step_addr(cmd_t c, logic [2:0] s, logic [17:0] a);
        logic [17:0] r;
        r = (s == 3'h1 || s == 3'h4) ? {3'h0, `CMD_ADDR_B} : {3'h0, `CMD_ADDR_A};
        if (c == CMD_PROGRAM && s == 3'h3)
            r = a;
        if (c == CMD_SECTOR_ERASE && s == 3'h5)
            r = a;
        if (c == CMD_ID_EXIT1)
            r = a;
        return r;
    endfunction

    // data of a sequence write; the upper byte of a code is don't care
    function automatic logic [7:0] step_code(cmd_t c, logic [2:0] s);
        logic [7:0] r;
        r = `CODE_UNLOCK_A;
        case (s)
            3'h1, 3'h4: r = `CODE_UNLOCK_B;
            3'h2:
            begin
                case (c)
                    CMD_PROGRAM: r = `CODE_PROGRAM;
                    CMD_ID_ENTRY: r = `CODE_ID_ENTRY;
                    CMD_ID_EXIT3: r = `CODE_ID_EXIT;
                    default: r = `CODE_ERASE_SETUP;
                endcase
            end
            3'h5:
            begin
                case (c)
                    CMD_CHIP_ERASE: r = `CODE_CHIP_ERASE;
                    CMD_SECTOR_ERASE: r = `CODE_SECTOR_ERASE;
                    default: r = `CODE_LOCKOUT;
                endcase
            end
            default: r = `CODE_UNLOCK_A;
        endcase
        if (c == CMD_ID_EXIT1)
            r = `CODE_ID_EXIT;
        return r;
    endfunction

    assign take = I_CMD_VALID && O_CMD_READY;
    assign seq_addr = step_addr(cmd_r, step_r, addr_r);
    assign seq_data = (cmd_r == CMD_PROGRAM && step_r == 3'h3) ? data_r :
                      {8'h00, step_code(cmd_r, step_r)};
    assign last_step = (cmd_r == CMD_PROGRAM) ? 3'h3 :
                       (cmd_r == CMD_ID_EXIT1) ? 3'h0 :
                       (cmd_r == CMD_ID_ENTRY || cmd_r == CMD_ID_EXIT3) ? 3'h2 : 3'h5;
    assign needs_poll = (cmd_r == CMD_PROGRAM) || (cmd_r == CMD_CHIP_ERASE) ||
                        (cmd_r == CMD_SECTOR_ERASE) || (cmd_r == CMD_LOCKOUT);
    assign poll_limit = (cmd_r == CMD_PROGRAM) ? PROG_TIMEOUT_CYC :
                        ERASE_TIMEOUT_CYC;
    assign poll_expired = (poll_cnt_r >= poll_limit);
    assign poll_equal = prev_valid_r && (bus_rdata[`TOGGLE_BIT] == prev_tog_r);
    assign write_last = (state_r == ST_WRITE) && bus_done && (step_r == last_step);
    assign bus_start = (state_r != ST_IDLE) && !issued_r && bus_idle;
    assign bus_write = (state_r == ST_WRITE);
    assign finish = ((state_r == ST_READ) && bus_done) ||
                    (write_last && !needs_poll) ||
                    ((state_r == ST_POLL) && bus_done && (poll_equal || poll_expired));

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (take)
                    state_nxt = (I_CMD == CMD_READ) ? ST_READ : ST_WRITE;
            ST_WRITE:
                if (write_last)
                    state_nxt = needs_poll ? ST_POLL : ST_IDLE;
            ST_READ:
                if (finish)
                    state_nxt = ST_IDLE;
            ST_POLL:
                if (finish)
                    state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            state_r <= ST_IDLE;
            cmd_r <= CMD_READ;
            addr_r <= 18'h00000;
            data_r <= 16'h0000;
            step_r <= 3'h0;
            issued_r <= 1'b0;
            done_r <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            state_r <= state_nxt;
            done_r <= finish;
            if (take)
            begin
                cmd_r <= I_CMD;
                addr_r <= I_ADDR;
                data_r <= I_DATA;
                step_r <= 3'h0;
            end
            else if (state_r == ST_WRITE && bus_done && !write_last)
                step_r <= step_r + 3'h1;
            if (bus_start)
                issued_r <= 1'b1;
            else if (bus_done)
                issued_r <= 1'b0;
        end
    end

    // poll tracking, result capture and identification mode tracking
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            prev_valid_r <= 1'b0;
            prev_tog_r <= 1'b0;
            poll_cnt_r <= 32'h00000000;
            timeout_r <= 1'b0;
            rdata_r <= 16'h0000;
            id_mode_r <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (take)
            begin
                prev_valid_r <= 1'b0;
                poll_cnt_r <= 32'h00000000;
                timeout_r <= 1'b0;
            end
            else if (state_r == ST_POLL)
            begin
                if (!poll_expired)
                    poll_cnt_r <= poll_cnt_r + 32'h00000001;
                if (bus_done)
                begin
                    prev_valid_r <= 1'b1;
                    prev_tog_r <= bus_rdata[`TOGGLE_BIT];
                    if (!poll_equal && poll_expired)
                        timeout_r <= 1'b1;
                end
            end
            if (bus_done && (state_r == ST_READ || state_r == ST_POLL))
                rdata_r <= bus_rdata;
            if (write_last && cmd_r == CMD_ID_ENTRY)
                id_mode_r <= 1'b1;
            else if (write_last && (cmd_r == CMD_ID_EXIT3 || cmd_r == CMD_ID_EXIT1))
                id_mode_r <= 1'b0;
        end
    end

    flash_bus_cycle u_bus
    (
        .i_clock(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_clk_en(I_CLK_EN),
        .i_start(bus_start),
        .i_write(bus_write),
        .i_addr(bus_write ? seq_addr : addr_r),
        .i_wdata(seq_data),
        .i_dq(I_DQ),
        .o_idle(bus_idle),
        .o_done(bus_done),
        .o_rdata(bus_rdata),
        .o_ce_n(O_CE_N),
        .o_oe_n(O_OE_N),
        .o_we_n(O_WE_N),
        .o_addr(O_ADDR),
        .o_dq(O_DQ),
        .o_dq_oe_n(O_DQ_OE_N)
    );

    assign O_CMD_READY = (state_r == ST_IDLE) && !done_r;
    assign O_DONE = done_r;
    assign O_TIMEOUT = timeout_r;
    assign O_RDATA = rdata_r;
    assign O_ID_MODE = id_mode_r;

endmodule

// File: testbench/flash_host_assertions.sv
// Purpose: pin rules of the flash host
// Assumes: sees top ports only
// Notes: poll address helper clears on done or on a write
`timescale 1ns/1ns
module flash_host_assertions (
    input wire logic I_CLOCK, // clock
    input wire logic I_RST_N, // reset
    input wire logic O_CMD_READY, // ready
    input wire logic O_DONE, // done pulse
    input wire logic O_CE_N, // chip select
    input wire logic O_OE_N, // output enable
    input wire logic O_WE_N, // write strobe
    input wire logic [17:0] O_ADDR, // address
    input wire logic [15:0] O_DQ, // data out
    input wire logic O_DQ_OE_N // data drive
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    logic seen_r;
    logic [17:0] rd_addr_r;
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N || O_DONE || !O_WE_N)
            seen_r <= 1'b0;
        else if (!O_OE_N)
            seen_r <= 1'b1;
        if (!O_OE_N)
            rd_addr_r <= O_ADDR;
    end
    wr_strobe_a: assert property (!O_WE_N |-> O_OE_N && !O_CE_N && !O_DQ_OE_N)
        else $error("write strobe with bad companions");
    wr_hold_a: assert property (!O_WE_N |-> $stable(O_ADDR) && $stable(O_DQ))
        else $error("address or data moved during write");
    wr_width_a: assert property ($fell(O_WE_N) |->
        (!O_WE_N)[*8] ##1 !O_WE_N ##1 !O_WE_N ##1 O_WE_N) else $error("write pulse width");
    wr_gap_a: assert property ($rose(O_WE_N) |-> O_WE_N[*8] ##1 O_WE_N ##1 O_WE_N)
        else $error("write high time short");
    rd_width_a: assert property ($fell(O_OE_N) |-> (!O_OE_N && !O_CE_N)[*8]
        ##1 !O_OE_N ##1 !O_OE_N ##1 !O_OE_N ##1 O_OE_N) else $error("read pulse width");
    rd_gap_a: assert property ($rose(O_OE_N) |-> O_OE_N[*8])
        else $error("read high time short");
    poll_addr_a: assert property ($fell(O_OE_N) && seen_r |-> O_ADDR == rd_addr_r)
        else $error("poll address moved");
    code_hi_a: assert property ($fell(O_WE_N) && O_ADDR[14:0] == 15'h5555 |->
        O_DQ[15:8] == 8'h00) else $error("code write upper byte set");
    code_2aaa_a: assert property ($fell(O_WE_N) && O_ADDR[14:0] == 15'h2aaa |->
        O_DQ == 16'h0055) else $error("second unlock write wrong");
    ready_idle_a: assert property (O_CMD_READY |-> O_CE_N && O_OE_N && O_WE_N)
        else $error("ready while bus busy");
    done_busy_a: assert property (O_DONE |-> !O_CMD_READY ##1 !O_DONE)
        else $error("ready in done cycle or long done pulse");
endmodule

bind flash_host flash_host_assertions flash_host_assertions_inst (.I_CLOCK(I_CLOCK),
    .I_RST_N(I_RST_N), .O_CMD_READY(O_CMD_READY), .O_DONE(O_DONE), .O_CE_N(O_CE_N),
    .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_ADDR(O_ADDR), .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N));

// File: testbench/flash_model.sv
// Purpose: behavioural parallel flash on the host pins
// Assumes: busy time counted in status reads
// Notes: released data pins show the inverse of the last value
`timescale 1ns/1ns
module flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h005a, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h00c3 // arbitrary value
) (
    input wire logic i_ce_n, // chip select
    input wire logic i_oe_n, // output enable
    input wire logic i_we_n, // write strobe
    input wire logic [17:0] i_addr, // address
    input wire logic [15:0] i_dq, // data bus
    input wire logic [15:0] i_busy_reads, // busy length
    output logic [15:0] o_dq // read data
);
    logic [15:0] mem [logic [17:0]];
    logic [15:0] pdata = 16'h0;
    logic [15:0] dq_r = 16'h0;
    logic [2:0] step = 3'd0;
    logic prog_arm = 1'b0;
    logic id_mode = 1'b0;
    logic locked = 1'b0;
    logic tog = 1'b1;
    logic erasing = 1'b0;
    logic wr_q = 1'b0;
    logic rd_q = 1'b0;
    int busy = 0;
    wire wr_act = !i_ce_n && !i_we_n && i_oe_n;
    wire rd_act = !i_ce_n && !i_oe_n;
    wire [14:0] ca = i_addr[14:0];
    wire [7:0] cd = i_dq[7:0];
    wire at5 = ca == 15'h5555;
    wire ua = at5 && cd == 8'haa;
    wire ub = ca == 15'h2aaa && cd == 8'h55;
    assign o_dq = dq_r;
    // one process serves both strobes, so every variable has a single writer
    always @(wr_act or rd_act)
    begin
        if (wr_q && !wr_act)
        begin
            if (prog_arm)
            begin
                mem[i_addr] = i_dq;
                pdata = i_dq;
                erasing = 1'b0;
                busy = i_busy_reads;
                prog_arm = 1'b0;
            end
            else if (cd == 8'hf0 && (step == 3'd0 || (step == 3'd2 && at5)))
            begin
                id_mode = 1'b0;
                step = 3'd0;
            end
            else
            begin
                if (step == 3'd2 && at5)
                begin
                    prog_arm = cd == 8'ha0;
                    id_mode = id_mode || cd == 8'h90;
                end
                if (step == 3'd5)
                begin
                    locked = locked || (at5 && cd == 8'h40);
                    if (at5 && cd == 8'h10)
                        mem.delete();
                    if (cd == 8'h30)
                        foreach (mem[k])
                            if (k[17:12] == i_addr[17:12])
                                mem[k] = 16'hffff;
                    erasing = 1'b1;
                    busy = i_busy_reads;
                end
                case (step)
                    3'd0: step = ua ? 3'd1 : 3'd0;
                    3'd1: step = ub ? 3'd2 : 3'd0;
                    3'd2: step = (at5 && cd == 8'h80) ? 3'd3 : 3'd0;
                    3'd3: step = ua ? 3'd4 : 3'd0;
                    3'd4: step = ub ? 3'd5 : 3'd0;
                    default: step = 3'd0;
                endcase
            end
        end
        if (!rd_q && rd_act)
        begin
            if (busy > 0)
            begin
                tog = ~tog;
                busy--;
                dq_r = {8'h00, erasing ? 1'b0 : ~pdata[7], tog, 6'h00};
            end
            else if (id_mode)
                dq_r = i_addr == 18'h0 ? MAKER_CODE : i_addr == 18'h1 ? PART_CODE :
                    {15'h0, locked};
            else
                dq_r = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
        end
        else if (rd_q && !rd_act)
            dq_r = ~dq_r;
        wr_q = (wr_act === 1'b1);
        rd_q = (rd_act === 1'b1);
    end
endmodule

// File: testbench/flash_host_tb.sv
// Purpose: self-checking bench for the flash host
// Assumes: flash_model on the far side
// Notes: each done pulse is matched with the oldest queued note
`timescale 1ns/1ns
module flash_host_tb;
    import flash_host_pkg::*;
    typedef struct packed {logic [15:0] rd; logic chk; logic to; logic ichk; logic idm;} note_t;
    localparam logic [15:0] MAKER = 16'h005a; // arbitrary value
    localparam logic [15:0] PART = 16'h00c3; // arbitrary value
    logic I_CLOCK = 0, I_RST_N = 0, I_CLK_EN = 1, I_CMD_VALID = 0;
    cmd_t I_CMD = CMD_READ;
    logic [17:0] I_ADDR = 0, aa, ab;
    logic [15:0] I_DATA = 0, da, db, busy_len = 5;
    logic O_CMD_READY, O_DONE, O_TIMEOUT, O_ID_MODE, O_CE_N, O_OE_N, O_WE_N, O_DQ_OE_N;
    logic [15:0] O_RDATA, O_DQ, mdq;
    logic [17:0] O_ADDR;
    wire [15:0] I_DQ = O_DQ_OE_N ? mdq : O_DQ;
    int err_count = 0, total_checks = 0, cyc = 0, dones = 0;
    logic [31:0] seed = 32'hb03b98f0, r;
    note_t exp_q[$];
    note_t n;
    always #10 I_CLOCK = ~I_CLOCK;
    flash_host #(.ERASE_TIMEOUT_CYC(32'd300)) flash_host_inst (.I_CLOCK(I_CLOCK),
        .I_RST_N(I_RST_N), .I_CLK_EN(I_CLK_EN), .I_CMD_VALID(I_CMD_VALID), .I_CMD(I_CMD),
        .I_ADDR(I_ADDR), .I_DATA(I_DATA), .O_CMD_READY(O_CMD_READY), .O_DONE(O_DONE),
        .O_TIMEOUT(O_TIMEOUT), .O_RDATA(O_RDATA), .O_ID_MODE(O_ID_MODE), .O_CE_N(O_CE_N),
        .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_ADDR(O_ADDR), .I_DQ(I_DQ), .O_DQ(O_DQ),
        .O_DQ_OE_N(O_DQ_OE_N));
    flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_model_inst (.i_ce_n(O_CE_N),
        .i_oe_n(O_OE_N), .i_we_n(O_WE_N), .i_addr(O_ADDR), .i_dq(I_DQ),
        .i_busy_reads(busy_len), .o_dq(mdq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] want, string what);
        total_checks++;
        if (got !== want)
        begin
            err_count++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // entered just after a rising edge; returns after the done pulse
    task automatic do_cmd(cmd_t c, logic [17:0] a, logic [15:0] d, note_t e);
        int k;
        int seen;
        seen = dones;
        exp_q.push_back(e);
        I_CMD = c;
        I_ADDR = a;
        I_DATA = d;
        I_CMD_VALID = 1'b1;
        k = 0;
        while (O_CMD_READY !== 1'b1 && k < 100)
        begin
            @(posedge I_CLOCK);
            #2;
            k++;
        end
        @(posedge I_CLOCK);
        #2;
        I_CMD_VALID = 1'b0;
        while (dones == seen && k < 15000)
        begin
            @(posedge I_CLOCK);
            #2;
            k++;
        end
        if (dones == seen)
        begin
            err_count++;
            $display("[ERR] %0t command did not finish", $time);
            give_verdict();
        end
    endtask
    always @(posedge I_CLOCK)
    begin
        cyc++;
        if (O_DONE === 1'b1 && exp_q.size() > 0)
        begin
            n = exp_q.pop_front();
            dones++;
            if (n.chk)
                chk(O_RDATA, n.rd, "read data");
            chk(16'(O_TIMEOUT), 16'(n.to), "timeout flag");
            if (n.ichk)
                chk(16'(O_ID_MODE), 16'(n.idm), "id mode flag");
        end
        if (cyc > 20000)
        begin
            err_count++;
            $display("[ERR] %0t run did not finish", $time);
            give_verdict();
        end
    end
    initial
    begin
        repeat (6) @(posedge I_CLOCK);
        #2;
        chk(16'({O_CMD_READY, O_CE_N, O_OE_N, O_WE_N, O_DQ_OE_N, O_ID_MODE}),
            16'h3e, "reset");
        I_RST_N = 1'b1;
        $display("test reset done");
        r = rnd();
        aa = {6'h04, r[11:0]};
        da = r[31:16];
        do_cmd(CMD_PROGRAM, aa, da, {da, 4'b1010});
        r = rnd();
        ab = {6'h08, r[11:0]};
        db = r[31:16];
        do_cmd(CMD_PROGRAM, ab, db, {db, 4'b1010});
        // a request held while the clock enable is low must not be taken
        I_CLK_EN = 1'b0;
        I_CMD = CMD_READ;
        I_CMD_VALID = 1'b1;
        repeat (3) @(posedge I_CLOCK);
        #2;
        chk(16'({O_CMD_READY, O_CE_N, O_OE_N}), 16'h7, "frozen take");
        I_CLK_EN = 1'b1;
        do_cmd(CMD_READ, aa, 16'h0, {da, 4'b1010});
        $display("test program done");
        do_cmd(CMD_SECTOR_ERASE, 18'h04100, 16'h0, {16'hffff, 4'b1010});
        do_cmd(CMD_READ, aa, 16'h0, {16'hffff, 4'b1010});
        do_cmd(CMD_READ, ab, 16'h0, {db, 4'b1010});
        busy_len = 9;
        do_cmd(CMD_CHIP_ERASE, ab, 16'h0, {16'hffff, 4'b1010});
        do_cmd(CMD_READ, ab, 16'h0, {16'hffff, 4'b1010});
        $display("test erase done");
        do_cmd(CMD_LOCKOUT, ab, 16'h0, {16'hffff, 4'b1010});
        do_cmd(CMD_ID_ENTRY, 18'h0, 16'h0, {16'h0, 4'b0011});
        do_cmd(CMD_READ, 18'h0, 16'h0, {MAKER, 4'b1011});
        do_cmd(CMD_READ, 18'h1, 16'h0, {PART, 4'b1011});
        do_cmd(CMD_READ, 18'h2, 16'h0, {16'h0001, 4'b1011});
        do_cmd(CMD_ID_EXIT3, 18'h0, 16'h0, {16'h0, 4'b0010});
        do_cmd(CMD_READ, 18'h2, 16'h0, {16'hffff, 4'b1010});
        do_cmd(CMD_ID_ENTRY, 18'h0, 16'h0, {16'h0, 4'b0011});
        do_cmd(CMD_ID_EXIT1, ab, 16'h0, {16'h0, 4'b0010});
        do_cmd(CMD_READ, 18'h1, 16'h0, {16'hffff, 4'b1010});
        $display("test id mode done");
        busy_len = 100;
        do_cmd(CMD_SECTOR_ERASE, 18'h08000, 16'h0, {16'h0, 4'b0110});
        $display("test timeout done");
        give_verdict();
    end
endmodule
